//--- common/aotf_consts.vh
`ifndef AOTF_CONSTS_VH
`define AOTF_CONSTS_VH

// register indices on the plain register port
`define AOTF_ADDR_W        4
`define AOTF_REG_CTRL      4'h0
`define AOTF_REG_EVENTS    4'h1

// field positions in the control/status word
`define AOTF_BIT_OVA       14
`define AOTF_BIT_OVB       13
`define AOTF_BIT_COVA      12
`define AOTF_BIT_COVB      11
`define AOTF_BIT_ACC_A_OVERFLOW_TRAP_ENABLE     10
`define AOTF_FIELD_MASK    16'h7C00

// reset values
`define AOTF_CTRL_RESET    16'h0000

// synchroniser depth for pin-side event inputs
`define AOTF_SYNC_STAGES   2

`endif

//--- hdl/aotf_sync.v
`timescale 1ns/1ps
`include "aotf_consts.vh"

// two-stage synchroniser with rising-edge pulse output
module aotf_sync (
	input  wire       clk,
	input  wire       rst,
	input  wire [3:0] async_in,
	output wire [3:0] rise
);

	reg [3:0] stage1;
	reg [3:0] stage2;
	reg [3:0] stage3;

	always @(posedge clk) begin
		if (rst) begin
			stage1 <= 4'h0;
			stage2 <= 4'h0;
			stage3 <= 4'h0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign rise = stage2 & ~stage3;

endmodule // aotf_sync

//--- hdl/aotf_trap_flags.v
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "aotf_consts.vh"

// Behaviour
// - accumulator A overflow trap sets bit 14
// - accumulator B overflow trap sets bit 13
// - A catastrophic overflow trap sets bit 12
// - B catastrophic overflow trap sets bit 11
// - bit 10 enables trap on A overflow
module aotf_trap_flags (
	input  wire        CLK,
	input  wire        RST,
	input  wire        OVF_A,
	input  wire        OVF_B,
	input  wire        CAT_OVF_A,
	input  wire        CAT_OVF_B,
	input  wire        OVF_B_TRAP_EN,
	input  wire        CAT_TRAP_EN,
	input  wire [3:0]  ADDR,
	input  wire [15:0] WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [15:0] RDATA,
	output reg         MATH_TRAP
);

	////////////////////////////////////////////////////////////////////////
	// event synchronisation

	wire [3:0] rise;

	aotf_sync u_sync (
		.clk      (CLK),
		.rst      (RST),
		.async_in ({OVF_A, OVF_B, CAT_OVF_A, CAT_OVF_B}),
		.rise     (rise)
	);

	reg        en_b_s1;
	reg        en_b_s2;
	reg        en_c_s1;
	reg        en_c_s2;

	always @(posedge CLK) begin
		if (RST) begin
			en_b_s1 <= 1'b0;
			en_b_s2 <= 1'b0;
			en_c_s1 <= 1'b0;
			en_c_s2 <= 1'b0;
		end else begin
			en_b_s1 <= OVF_B_TRAP_EN;
			en_b_s2 <= en_b_s1;
			en_c_s1 <= CAT_TRAP_EN;
			en_c_s2 <= en_c_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trap qualification

	reg        acc_a_overflow_trap_enable;
	reg        acc_a_overflow_flag;
	reg        acc_b_overflow_flag;
	reg        acc_a_catastrophic_flag;
	reg        acc_b_catastrophic_flag;

	wire       ev_a;
	wire       ev_b;
	wire       ev_ca;
	wire       ev_cb;

	localparam idx_acc_a_ovf = 3;
	localparam idx_acc_b_ovf = 2;
	localparam idx_acc_a_cat = 1;
	localparam idx_acc_b_cat = 0;

	assign ev_a  = rise[idx_acc_a_ovf] & acc_a_overflow_trap_enable;
	assign ev_b  = rise[idx_acc_b_ovf] & en_b_s2;
	assign ev_ca = rise[idx_acc_a_cat] & en_c_s2;
	assign ev_cb = rise[idx_acc_b_cat] & en_c_s2;

	////////////////////////////////////////////////////////////////////////
	// control / status register

	wire       wr_ctrl;
	wire       rd_ctrl;
	wire       rd_events;

	// register index decode, shared by the write and read paths
	function reg_hit;
		input [`AOTF_ADDR_W-1:0] addr;
		input [`AOTF_ADDR_W-1:0] idx;
		begin
			reg_hit = (addr == idx);
		end
	endfunction

	assign wr_ctrl   = WR & reg_hit(ADDR, `AOTF_REG_CTRL);
	assign rd_ctrl   = RD & reg_hit(ADDR, `AOTF_REG_CTRL);
	assign rd_events = RD & reg_hit(ADDR, `AOTF_REG_EVENTS);

	// set wins over a software clear in the same cycle
	function sticky;
		input cur;
		input set;
		input wr;
		input wbit;
		begin
			if (set)
				sticky = 1'b1;
			else if (wr && !wbit)
				sticky = 1'b0;
			else
				sticky = cur;
		end
	endfunction

	reg        next_acc_a_overflow_trap_enable;
	reg        next_acc_a_overflow_flag;
	reg        next_acc_b_overflow_flag;
	reg        next_acc_a_catastrophic_flag;
	reg        next_acc_b_catastrophic_flag;

	// write 0 clears a flag, write 1 leaves it alone
	always @* begin
		next_acc_a_overflow_trap_enable = acc_a_overflow_trap_enable;
		if (wr_ctrl) begin
			next_acc_a_overflow_trap_enable = WDATA[`AOTF_BIT_ACC_A_OVERFLOW_TRAP_ENABLE];
		end
		next_acc_a_overflow_flag = sticky(acc_a_overflow_flag, ev_a, wr_ctrl,
			WDATA[`AOTF_BIT_OVA]);
		next_acc_b_overflow_flag = sticky(acc_b_overflow_flag, ev_b, wr_ctrl,
			WDATA[`AOTF_BIT_OVB]);
		next_acc_a_catastrophic_flag = sticky(acc_a_catastrophic_flag, ev_ca, wr_ctrl,
			WDATA[`AOTF_BIT_COVA]);
		next_acc_b_catastrophic_flag = sticky(acc_b_catastrophic_flag, ev_cb, wr_ctrl,
			WDATA[`AOTF_BIT_COVB]);
	end

	////////////////////////////////////////////////////////////////////////
	// control / status registers

	always @(posedge CLK) begin
		if (RST) begin
			acc_a_overflow_trap_enable <= 1'b0;
		end else begin
			acc_a_overflow_trap_enable <= next_acc_a_overflow_trap_enable;
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			acc_a_overflow_flag <= 1'b0;
		end else begin
			acc_a_overflow_flag <= next_acc_a_overflow_flag;
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			acc_b_overflow_flag <= 1'b0;
		end else begin
			acc_b_overflow_flag <= next_acc_b_overflow_flag;
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			acc_a_catastrophic_flag <= 1'b0;
		end else begin
			acc_a_catastrophic_flag <= next_acc_a_catastrophic_flag;
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			acc_b_catastrophic_flag <= 1'b0;
		end else begin
			acc_b_catastrophic_flag <= next_acc_b_catastrophic_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trap request and read port

	wire [15:0] ctrl_word;
	wire [15:0] event_word;

	assign ctrl_word = {1'b0, acc_a_overflow_flag, acc_b_overflow_flag,
		acc_a_catastrophic_flag, acc_b_catastrophic_flag,
		acc_a_overflow_trap_enable, 10'h000};
	assign event_word = {12'h000, en_b_s2, en_c_s2, 2'h0};

	reg [15:0] next_rdata;
	reg        next_math_trap;

	always @* begin
		next_math_trap = ev_a | ev_b | ev_ca | ev_cb;
		next_rdata     = 16'h0000;
		if (rd_ctrl) begin
			next_rdata = ctrl_word;
		end else if (rd_events) begin
			next_rdata = event_word;
		end
	end

	// one pulse per cycle in which any event qualifies; events in the same cycle share a pulse
	always @(posedge CLK) begin
		if (RST) begin
			MATH_TRAP <= 1'b0;
		end else begin
			MATH_TRAP <= next_math_trap;
		end
	end

	// read data only stand in the cycle after the strobe
	always @(posedge CLK) begin
		if (RST) begin
			RDATA <= `AOTF_CTRL_RESET;
		end else begin
			RDATA <= next_rdata;
		end
	end

endmodule // aotf_trap_flags

//--- dv/aotf_chk_sva.sv
`timescale 1ns/1ps
`include "aotf_consts.vh"
module aotf_chk (
	input wire        CLK,
	input wire        RST,
	input wire        OVF_A,
	input wire        OVF_B,
	input wire        CAT_OVF_A,
	input wire        CAT_OVF_B,
	input wire [3:0]  ADDR,
	input wire        RD,
	input wire [15:0] RDATA,
	input wire        MATH_TRAP
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_quiet;
		!(OVF_A || OVF_B || CAT_OVF_A || CAT_OVF_B) [*4];
	endsequence
	property p_quiet; s_quiet |-> !MATH_TRAP; endproperty
	a_quiet: assert property (p_quiet) else $error("trap without event");
	property p_one;
		MATH_TRAP && $past({OVF_A, OVF_B, CAT_OVF_A, CAT_OVF_B}, 2) ==
			$past({OVF_A, OVF_B, CAT_OVF_A, CAT_OVF_B}, 3) |=> !MATH_TRAP;
	endproperty
	a_one: assert property (p_one) else $error("trap pulse too long");
	property p_idle; !$past(RD) |-> RDATA == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	property p_rst; $past(RST) |-> !MATH_TRAP && RDATA == 16'h0000; endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");
	property p_rsv;
		$past(RD) && $past(ADDR) == `AOTF_REG_CTRL |-> (RDATA & ~`AOTF_FIELD_MASK) == 16'h0000;
	endproperty
	a_rsv: assert property (p_rsv) else $error("bits outside field set");
	property p_map; $past(RD) && $past(ADDR) > 4'h1 |-> RDATA == 16'h0000; endproperty
	a_map: assert property (p_map) else $error("unmapped read not zero");
endmodule // aotf_chk
bind aotf_trap_flags aotf_chk u_aotf_chk (.CLK, .RST, .OVF_A, .OVF_B, .CAT_OVF_A, .CAT_OVF_B,
	.ADDR, .RD, .RDATA, .MATH_TRAP);

//--- dv/aotf_trap_flags_tb.sv
`timescale 1ns/1ps
module aotf_trap_flags_tb;
	reg         CLK = 0, RST = 1, WR = 0, RD = 0, en_b = 0, en_c = 0;
	reg  [3:0]  ev = 0, ADDR = 0;
	reg  [15:0] WDATA = 0;
	wire [15:0] RDATA;
	wire        MATH_TRAP;
	integer     fails = 0, n_compared = 0, traps = 0, i;
	reg  [19:0] rows [0:3];
	aotf_trap_flags u_aotf_trap_flags (.CLK, .RST, .OVF_A(ev[3]), .OVF_B(ev[2]),
		.CAT_OVF_A(ev[1]), .CAT_OVF_B(ev[0]), .OVF_B_TRAP_EN(en_b), .CAT_TRAP_EN(en_c),
		.ADDR, .WDATA, .WR, .RD, .RDATA, .MATH_TRAP);
	initial forever #4 CLK = ~CLK;
	always @(negedge CLK) if (MATH_TRAP === 1'b1) traps = traps + 1;
	task chk(input [15:0] got, input [15:0] exp, input [127:0] what);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("ERROR %0s exp %h got %h", what, exp, got);
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		@(posedge CLK) {WR, ADDR, WDATA} <= {1'b1, a, d};
		@(posedge CLK) WR <= 0;
	endtask
	task rd(input [3:0] a, input [15:0] e);
		@(posedge CLK) {RD, ADDR} <= {1'b1, a};
		@(posedge CLK) RD <= 0;
		@(negedge CLK) chk(RDATA, e, "rdata");
	endtask
	task hit(input [3:0] e);
		@(posedge CLK) ev <= e;
		repeat (5) @(posedge CLK);
		ev <= 0;
		repeat (3) @(posedge CLK);
	endtask
	task stop_test;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#20000 fails = fails + 1;
		stop_test;
	end
	initial begin
		rows[0] = 20'h84400;
		rows[1] = 20'h42400;
		rows[2] = 20'h21400;
		rows[3] = 20'h10C00;
		repeat (10) @(posedge CLK);
		RST <= 0;
		rd(0, 16'h0000);
		rd(5, 16'h0000);
		wr(0, 16'h0400);
		{en_b, en_c} <= 2'h3;
		for (i = 0; i < 4; i = i + 1) begin
			hit(rows[i][19:16]);
			rd(0, rows[i][15:0]);
			wr(0, 16'h0400);
			rd(0, 16'h0400);
		end
		$display("rows done");
		rd(1, 16'h000C);
		@(posedge CLK) en_b <= 0;
		repeat (3) @(posedge CLK);
		rd(1, 16'h0004);
		hit(4'h4);
		hit(4'h1);
		rd(0, 16'h0C00);
		@(posedge CLK) {en_b, en_c} <= 2'h2;
		repeat (3) @(posedge CLK);
		hit(4'h4);
		hit(4'h2);
		rd(0, 16'h2C00);
		wr(0, 16'h7C00);
		rd(0, 16'h2C00);
		wr(0, 16'h0400);
		$display("enables done");
		@(posedge CLK) ev <= 4'h8;
		@(posedge CLK);
		wr(0, 16'h0400);
		ev <= 0;
		repeat (3) @(posedge CLK);
		rd(0, 16'h4400);
		wr(0, 16'h0000);
		hit(4'h8);
		rd(0, 16'h0000);
		chk(traps[15:0], 16'h0007, "trap count");
		$display("awkward done");
		wr(0, 16'h0400);
		hit(4'h8);
		rd(0, 16'h4400);
		@(posedge CLK) RST <= 1;
		repeat (3) @(posedge CLK);
		RST <= 0;
		rd(0, 16'h0000);
		chk(traps[15:0], 16'h0008, "trap count");
		$display("reset done");
		stop_test;
	end
endmodule // aotf_trap_flags_tb
